// ===== verilog/esta_stats.sv
// Purpose: per-port ethernet frame statistics with clear and uptime
// Assumes: at most one rx, one tx, one request and one failure event per cycle
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps
`include "esta_cfg.svh"

module esta_stats #(
    parameter int PORTS       = 4,
    parameter int W           = 32,
    parameter int MAX_FRAME   = 1518,
    parameter int TICK_CYCLES = `ESTA_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       nrst,

    // port mode
    input  wire logic [PORTS-1:0]           half_duplex,

    // receive end-of-frame status
    input  wire logic                       rx_done,
    input  wire logic [$clog2(PORTS)-1:0]   rx_port,
    input  wire esta_pkg::esta_len_t        rx_len,
    input  wire logic                       rx_fcs_bad,
    input  wire logic                       rx_dribble,
    input  wire logic                       rx_mac_err,
    input  wire logic                       rx_pause,
    input  wire logic                       rx_stp,
    input  wire logic                       rx_rstp,
    input  wire logic                       rx_gvrp,
    input  wire logic                       rx_gmrp,

    // transmit end-of-frame status
    input  wire logic                       tx_done,
    input  wire logic [$clog2(PORTS)-1:0]   tx_port,
    input  wire esta_pkg::esta_len_t        tx_len,
    input  wire logic                       tx_ok,
    input  wire logic                       tx_fcs_bad,
    input  wire logic                       tx_underrun,
    input  wire logic [4:0]                 tx_coll,
    input  wire logic                       tx_excess,
    input  wire logic                       tx_pause,
    input  wire logic                       tx_stp,
    input  wire logic                       tx_rstp,
    input  wire logic                       tx_gvrp,
    input  wire logic                       tx_gmrp,

    // transmit requests from upper layers
    input  wire logic                       req_done,
    input  wire logic [$clog2(PORTS)-1:0]   req_port,
    input  wire esta_pkg::esta_dst_e        req_dst,

    // garp registration failures
    input  wire logic                       fail_done,
    input  wire logic [$clog2(PORTS)-1:0]   fail_port,
    input  wire logic                       fail_gmrp,

    // clear requests
    input  wire logic                       clr_one,
    input  wire logic [$clog2(PORTS)-1:0]   clr_port,
    input  wire logic                       clr_all,

    // read port
    input  wire logic                       rd_req,
    input  wire logic [$clog2(PORTS)-1:0]   rd_port,
    input  wire logic [5:0]                 rd_sel,
    output logic                            rd_valid,
    output logic [W-1:0]                    rd_data
);

    // ****************************************
    // sizes
    // ****************************************
    localparam int PW   = $clog2(PORTS);
    localparam int NCNT = `ESTA_N_CNT;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [PORTS-1:0][NCNT-1:0][W-1:0] cnt;
        logic [PORTS-1:0][5:0]             sec;
        logic [PORTS-1:0][5:0]             min;
        logic [PORTS-1:0][4:0]             hour;
        logic [PORTS-1:0][15:0]            day;

        logic                              rd_valid;
        logic [W-1:0]                      rd_data;
    } esta_state_s;

    esta_state_s st;
    esta_state_s next_st;

    logic [NCNT-1:0] rx_inc;
    logic [NCNT-1:0] tx_inc;
    logic            tick;

    // ****************************************
    // classification and time base
    // ****************************************
    esta_classify #(
        .NCNT        (NCNT)
    ) u_classify (
        .rx_len      (rx_len),
        .rx_fcs_bad  (rx_fcs_bad),
        .rx_dribble  (rx_dribble),
        .rx_mac_err  (rx_mac_err),
        .rx_pause    (rx_pause),
        .rx_half     (half_duplex[rx_port]),
        .rx_stp      (rx_stp),
        .rx_rstp     (rx_rstp),
        .rx_gvrp     (rx_gvrp),
        .rx_gmrp     (rx_gmrp),
        .tx_len      (tx_len),
        .tx_max      (esta_pkg::esta_len_t'(MAX_FRAME)),
        .tx_ok       (tx_ok),
        .tx_fcs_bad  (tx_fcs_bad),
        .tx_underrun (tx_underrun),
        .tx_coll     (tx_coll),
        .tx_excess   (tx_excess),
        .tx_pause    (tx_pause),
        .tx_half     (half_duplex[tx_port]),
        .tx_stp      (tx_stp),
        .tx_rstp     (tx_rstp),
        .tx_gvrp     (tx_gvrp),
        .tx_gmrp     (tx_gmrp),
        .rx_inc      (rx_inc),
        .tx_inc      (tx_inc)
    );

    esta_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock       (clock),
        .nrst        (nrst),
        .tick        (tick)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic         clr;
        logic [W-1:0] add;
        int           req_slot;
        int           fail_slot;

        clr = 1'b0;
        add = '0;
        req_slot = `ESTA_C_TX_UC + int'(req_dst);
        fail_slot = fail_gmrp ? `ESTA_C_GMRP_FAIL : `ESTA_C_GVRP_FAIL;
        next_st = st;

        // ****************************************
        // counter updates
        // ****************************************
        for (int p = 0; p < PORTS; p++) begin
            clr = clr_all
                || (clr_one && clr_port == PW'(p));

            for (int c = 0; c < NCNT; c++) begin
                add = '0;
                // counters move only on the status strobes, once each
                if (rx_done && rx_port == PW'(p) && rx_inc[c]) begin
                    add = W'(1);
                end
                if (tx_done && tx_port == PW'(p) && tx_inc[c]) begin
                    if (c == `ESTA_C_TX_OCT) begin
                        add = W'(tx_len);
                    end else if (c == `ESTA_C_COLL_SUM) begin
                        add = W'(tx_coll);
                    end else begin
                        add = W'(1);
                    end
                end
                if (req_done && req_port == PW'(p) && c == req_slot
                    && req_dst != 2'h3) begin
                    add = W'(1);
                end
                if (fail_done && fail_port == PW'(p) && c == fail_slot) begin
                    add = W'(1);
                end
                // an event in the clear cycle survives as the first count
                next_st.cnt[p][c] = (clr ? '0 : st.cnt[p][c]) + add;
            end

            // ****************************************
            // uptime
            // ****************************************
            // elapsed time; the sub-second phase is shared, so the first
            // second after a clear may be short by up to one tick
            if (clr) begin
                next_st.sec[p]  = 6'h00;
                next_st.min[p]  = 6'h00;
                next_st.hour[p] = 5'h00;
                next_st.day[p]  = 16'h0000;
            end else if (tick) begin
                if (st.sec[p] != `ESTA_SEC_LAST) begin
                    next_st.sec[p] = st.sec[p] + 6'h01;
                end else begin
                    next_st.sec[p] = 6'h00;
                    if (st.min[p] != `ESTA_MIN_LAST) begin
                        next_st.min[p] = st.min[p] + 6'h01;
                    end else begin
                        next_st.min[p] = 6'h00;
                        if (st.hour[p] != `ESTA_HOUR_LAST) begin
                            next_st.hour[p] = st.hour[p] + 5'h01;
                        end else begin
                            next_st.hour[p] = 5'h00;
                            next_st.day[p] = st.day[p] + 16'h0001;
                        end
                    end
                end
            end
        end

        // ****************************************
        // read snapshot
        // ****************************************
        // read: a snapshot taken into a flop, unchanged until the next read
        next_st.rd_valid = rd_req;

        if (rd_req) begin
            next_st.rd_data = '0;
            if (int'(rd_port) < PORTS) begin
                if (int'(rd_sel) < NCNT) begin
                    next_st.rd_data = st.cnt[rd_port][rd_sel];
                end else begin
                    unique case (rd_sel)
                        6'(`ESTA_S_TX_ERRSUM),
                        6'(`ESTA_S_TX_DISC): begin
                            next_st.rd_data = st.cnt[rd_port][`ESTA_C_TX_SCOL]
                                            + st.cnt[rd_port][`ESTA_C_TX_MCOL]
                                            + st.cnt[rd_port][`ESTA_C_TX_XCOL];
                        end
                        6'(`ESTA_S_UP_SEC): begin
                            next_st.rd_data = W'(st.sec[rd_port]);
                        end
                        6'(`ESTA_S_UP_MIN): begin
                            next_st.rd_data = W'(st.min[rd_port]);
                        end
                        6'(`ESTA_S_UP_HOUR): begin
                            next_st.rd_data = W'(st.hour[rd_port]);
                        end
                        6'(`ESTA_S_UP_DAY): begin
                            next_st.rd_data = W'(st.day[rd_port]);
                        end
                        default: begin
                            next_st.rd_data = '0;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rd_valid = st.rd_valid;
    assign rd_data  = st.rd_data;

endmodule // esta_stats

// ===== verilog/esta_cfg.svh
// Purpose: constants for the port statistics block
// Assumes: one 40 MHz system clock
// Notes:   counter slot numbers are also the read select codes
`ifndef ESTA_CFG_SVH
`define ESTA_CFG_SVH

// ****************************************
// frame length limits, octets incl. fcs
// ****************************************
`define ESTA_LEN_MIN      16'h0040
`define ESTA_LEN_127      16'h007F
`define ESTA_LEN_255      16'h00FF
`define ESTA_LEN_511      16'h01FF
`define ESTA_LEN_1023     16'h03FF
`define ESTA_LEN_MAX      16'h05EE
`define ESTA_LEN_TAGGED   16'h05F2

// ****************************************
// counter slots
// ****************************************
`define ESTA_C_RX_UNDER   0
`define ESTA_C_RX_ALIGN   1
`define ESTA_C_RX_FCS     2
`define ESTA_C_RX_JABBER  3
`define ESTA_C_RX_PAUSE   4
`define ESTA_C_RX_BIN     5
`define ESTA_N_RX_BIN     8
`define ESTA_C_RX_ERRSUM  13
`define ESTA_C_TX_OCT     14
`define ESTA_C_TX_BIN     15
`define ESTA_N_TX_BIN     7
`define ESTA_C_TX_OK      22
`define ESTA_C_TX_UC      23
`define ESTA_C_TX_FCS     26
`define ESTA_C_TX_OVER    27
`define ESTA_C_TX_UNDRUN  28
`define ESTA_C_TX_SCOL    29
`define ESTA_C_TX_MCOL    30
`define ESTA_C_TX_XCOL    31
`define ESTA_C_STP_RX     32
`define ESTA_C_STP_TX     33
`define ESTA_C_RSTP_RX    34
`define ESTA_C_RSTP_TX    35
`define ESTA_C_TX_PAUSE   36
`define ESTA_C_GVRP_RX    37
`define ESTA_C_GVRP_TX    38
`define ESTA_C_GVRP_FAIL  39
`define ESTA_C_GMRP_RX    40
`define ESTA_C_GMRP_TX    41
`define ESTA_C_GMRP_FAIL  42
`define ESTA_C_COLL_SUM   43
`define ESTA_N_CNT        44

// ****************************************
// derived read selects
// ****************************************
`define ESTA_S_TX_ERRSUM  44
`define ESTA_S_TX_DISC    45
`define ESTA_S_UP_SEC     46
`define ESTA_S_UP_MIN     47
`define ESTA_S_UP_HOUR    48
`define ESTA_S_UP_DAY     49

// ****************************************
// elapsed time
// ****************************************
`define ESTA_CLK_HZ       40000000
`define ESTA_TICK_S       1
`define ESTA_TICK_CYCLES  (`ESTA_CLK_HZ * `ESTA_TICK_S)
`define ESTA_SEC_LAST     6'h3B
`define ESTA_MIN_LAST     6'h3B
`define ESTA_HOUR_LAST    5'h17

`endif

// ===== verilog/esta_pkg.sv
// Purpose: shared types of the port statistics block
// Assumes: nothing
// Notes:   constants live in esta_cfg.svh
package esta_pkg;

    typedef logic [15:0] esta_len_t;

    typedef enum logic [1:0] {
        ESTA_DST_UC = 2'h0,
        ESTA_DST_MC = 2'h1,
        ESTA_DST_BC = 2'h2
    } esta_dst_e;

endpackage

// ===== verilog/esta_tick.sv
// Purpose: one-second tick for the elapsed time counters
// Assumes: TICK_CYCLES at least 2
// Notes:   free running; clears do not realign its phase
`timescale 1ns/100ps
`include "esta_cfg.svh"

module esta_tick #(
    parameter int TICK_CYCLES = `ESTA_TICK_CYCLES
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // tick out
    output logic      tick
);

    typedef struct packed {
        logic [31:0] div;
        logic        tick;
    } esta_tick_s;

    esta_tick_s st;
    esta_tick_s next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.div == 32'(TICK_CYCLES - 1)) begin
            next_st.div = 32'h0000_0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

endmodule // esta_tick

// ===== verilog/esta_classify.sv
// Purpose: sort one end-of-frame status into counter increments
// Assumes: status fields valid while the done strobe is high
// Notes:   purely combinational
`timescale 1ns/100ps
`include "esta_cfg.svh"

module esta_classify #(
    parameter int NCNT = `ESTA_N_CNT
) (
    // receive status
    input  wire esta_pkg::esta_len_t rx_len,
    input  wire logic                rx_fcs_bad,
    input  wire logic                rx_dribble,
    input  wire logic                rx_mac_err,
    input  wire logic                rx_pause,
    input  wire logic                rx_half,
    input  wire logic                rx_stp,
    input  wire logic                rx_rstp,
    input  wire logic                rx_gvrp,
    input  wire logic                rx_gmrp,
    // transmit status
    input  wire esta_pkg::esta_len_t tx_len,
    input  wire esta_pkg::esta_len_t tx_max,
    input  wire logic                tx_ok,
    input  wire logic                tx_fcs_bad,
    input  wire logic                tx_underrun,
    input  wire logic [4:0]          tx_coll,
    input  wire logic                tx_excess,
    input  wire logic                tx_pause,
    input  wire logic                tx_half,
    input  wire logic                tx_stp,
    input  wire logic                tx_rstp,
    input  wire logic                tx_gvrp,
    input  wire logic                tx_gmrp,
    // increments
    output logic [NCNT-1:0]          rx_inc,
    output logic [NCNT-1:0]          tx_inc
);

    logic rx_short;
    logic rx_normal;
    logic rx_long;
    logic tx_normal;
    int   rx_bin;
    int   tx_bin;

    always_comb begin
        rx_short  = rx_len < `ESTA_LEN_MIN;
        rx_long   = rx_len > `ESTA_LEN_MAX;
        rx_normal = !rx_short && !rx_long;
        tx_normal = tx_len >= `ESTA_LEN_MIN && tx_len <= `ESTA_LEN_MAX;
        // runts share the lowest bin so every frame lands in one bin
        if (rx_len <= `ESTA_LEN_MIN)         rx_bin = 0;
        else if (rx_len <= `ESTA_LEN_127)    rx_bin = 1;
        else if (rx_len <= `ESTA_LEN_255)    rx_bin = 2;
        else if (rx_len <= `ESTA_LEN_511)    rx_bin = 3;
        else if (rx_len <= `ESTA_LEN_1023)   rx_bin = 4;
        else if (rx_len <= `ESTA_LEN_MAX)    rx_bin = 5;
        else if (rx_len <= `ESTA_LEN_TAGGED) rx_bin = 6;
        else                                 rx_bin = 7;
        // transmit has no bin above the upper one, long frames all go there
        if (tx_len <= `ESTA_LEN_MIN)         tx_bin = 0;
        else if (tx_len <= `ESTA_LEN_127)    tx_bin = 1;
        else if (tx_len <= `ESTA_LEN_255)    tx_bin = 2;
        else if (tx_len <= `ESTA_LEN_511)    tx_bin = 3;
        else if (tx_len <= `ESTA_LEN_1023)   tx_bin = 4;
        else if (tx_len <= `ESTA_LEN_MAX)    tx_bin = 5;
        else                                 tx_bin = 6;

        rx_inc = '0;
        rx_inc[`ESTA_C_RX_UNDER]  = rx_short;
        rx_inc[`ESTA_C_RX_ALIGN]  = rx_normal && rx_fcs_bad && rx_dribble;
        rx_inc[`ESTA_C_RX_FCS]    = rx_normal && rx_fcs_bad && !rx_dribble;
        rx_inc[`ESTA_C_RX_JABBER] = rx_long && rx_fcs_bad;
        rx_inc[`ESTA_C_RX_PAUSE]  = rx_pause && !rx_half;
        rx_inc[`ESTA_C_RX_BIN + rx_bin] = 1'b1;
        rx_inc[`ESTA_C_RX_ERRSUM] = rx_fcs_bad || rx_short || rx_mac_err;
        rx_inc[`ESTA_C_STP_RX]    = rx_stp;
        rx_inc[`ESTA_C_RSTP_RX]   = rx_rstp;
        rx_inc[`ESTA_C_GVRP_RX]   = rx_gvrp;
        rx_inc[`ESTA_C_GMRP_RX]   = rx_gmrp;

        tx_inc = '0;
        tx_inc[`ESTA_C_TX_OCT]    = 1'b1;
        tx_inc[`ESTA_C_TX_BIN + tx_bin] = 1'b1;
        tx_inc[`ESTA_C_TX_OK]     = tx_ok;
        tx_inc[`ESTA_C_TX_FCS]    = tx_normal && tx_fcs_bad;
        tx_inc[`ESTA_C_TX_OVER]   = tx_len > tx_max;
        tx_inc[`ESTA_C_TX_UNDRUN] = tx_underrun;
        tx_inc[`ESTA_C_TX_SCOL]   = tx_ok && tx_coll == 5'h01;
        tx_inc[`ESTA_C_TX_MCOL]   = tx_ok && tx_coll >= 5'h02;
        tx_inc[`ESTA_C_TX_XCOL]   = tx_excess;
        tx_inc[`ESTA_C_COLL_SUM]  = tx_coll != 5'h00;
        tx_inc[`ESTA_C_TX_PAUSE]  = tx_pause && !tx_half;
        tx_inc[`ESTA_C_STP_TX]    = tx_stp;
        tx_inc[`ESTA_C_RSTP_TX]   = tx_rstp;
        tx_inc[`ESTA_C_GVRP_TX]   = tx_gvrp;
        tx_inc[`ESTA_C_GMRP_TX]   = tx_gmrp;
    end

endmodule // esta_classify

// ===== tb/esta_stats_assertions.sv
// Purpose: port level checks of esta_stats
// Assumes: one clock domain, reads answered one cycle late
// Notes:   bound to every esta_stats instance
`timescale 1ns/100ps
module esta_stats_assertions #(parameter int PORTS = 4, parameter int W = 32) (
    // clock, reset and mode
    input wire logic clock, nrst,
    input wire logic [PORTS-1:0] half_duplex,
    // events
    input wire logic rx_done, rx_pause, tx_done, req_done, fail_done, clr_all,
    input wire logic [$clog2(PORTS)-1:0] rx_port, tx_port,
    input wire esta_pkg::esta_len_t rx_len, tx_len,
    // read port
    input wire logic rd_req, rd_valid,
    input wire logic [$clog2(PORTS)-1:0] rd_port,
    input wire logic [5:0] rd_sel,
    input wire logic [W-1:0] rd_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // a clear with no event beside it, so a counter read in the next cycle must see zero
    wire quiet = !rx_done && !tx_done && !req_done && !fail_done;
    sequence s_clear; clr_all && quiet; endsequence
    sequence s_read(s, p); rd_req && rd_sel == s && rd_port == p; endsequence
    a_read_lat: assert property (rd_req |=> rd_valid)
        else $error("read not answered");
    a_valid_pulse: assert property (!rd_req |=> !rd_valid)
        else $error("read valid without read");
    a_data_hold: assert property (!rd_req |=> $stable(rd_data))
        else $error("read data moved");
    a_unused_zero: assert property (rd_req && rd_sel > 6'h31 |=> rd_data == 0)
        else $error("unused select not zero");
    a_clear_zero: assert property (s_clear ##1 (rd_req && rd_sel < 6'h2E) |=> rd_data == 0)
        else $error("counter not cleared");
    a_under_count: assert property (s_clear ##1 (rx_done && rx_len < 16'h0040)
        ##1 s_read(6'h00, $past(rx_port)) |=> rd_data == 1) else $error("undersize miscounted");
    a_pause_half: assert property (s_clear ##1 (rx_done && rx_pause && half_duplex[rx_port])
        ##1 s_read(6'h04, $past(rx_port)) |=> rd_data == 0) else $error("half duplex pause counted");
    a_tx_octets: assert property (s_clear ##1 tx_done
        ##1 s_read(6'h0E, $past(tx_port)) |=> rd_data == $past(tx_len, 2)) else $error("octets wrong");
endmodule // esta_stats_assertions
bind esta_stats esta_stats_assertions #(.PORTS(PORTS), .W(W)) esta_stats_assertions_inst (
    .clock, .nrst, .half_duplex, .rx_done, .rx_pause, .tx_done, .req_done, .fail_done, .clr_all,
    .rx_port, .tx_port, .rx_len, .tx_len, .rd_req, .rd_valid, .rd_port, .rd_sel, .rd_data);

// ===== tb/esta_mac_model.sv
// Purpose: end-of-frame status source in place of the port mac
// Assumes: tasks entered just after a rising edge
// Notes:   fields are scrambled between frames so nothing stale looks valid
`timescale 1ns/100ps
module esta_mac_model (
    input  wire logic clock,
    output logic rx_done, tx_done,
    output wire logic rx_fcs_bad, rx_dribble, rx_mac_err, rx_pause, rx_stp, rx_rstp, rx_gvrp,
    output wire logic rx_gmrp, tx_ok, tx_fcs_bad, tx_underrun, tx_excess, tx_pause, tx_stp,
    output wire logic tx_rstp, tx_gvrp, tx_gmrp,
    output wire logic [1:0] rx_port, tx_port,
    output wire logic [4:0] tx_coll,
    output wire esta_pkg::esta_len_t rx_len, tx_len
);
    logic [25:0] rxv = '0;
    logic [31:0] txv = '0;
    assign {rx_port, rx_len, rx_fcs_bad, rx_dribble, rx_mac_err, rx_pause, rx_stp, rx_rstp,
            rx_gvrp, rx_gmrp} = rxv;
    assign {tx_port, tx_len, tx_ok, tx_fcs_bad, tx_underrun, tx_coll, tx_excess, tx_pause,
            tx_stp, tx_rstp, tx_gvrp, tx_gmrp} = txv;
    initial begin
        rx_done = 1'b0;
        tx_done = 1'b0;
    end
    task automatic rx(input logic [1:0] p, input logic [15:0] len, input logic [7:0] f);
        rxv = {p, len, f};
        rx_done = 1'b1;
        @(posedge clock);
        #1;
        rx_done = 1'b0;
        rxv = ~rxv;
    endtask
    task automatic tx(input logic [1:0] p, input logic [15:0] len, input logic [13:0] f);
        txv = {p, len, f};
        tx_done = 1'b1;
        @(posedge clock);
        #1;
        tx_done = 1'b0;
        txv = ~txv;
    endtask
endmodule // esta_mac_model

// ===== tb/esta_stats_bench.sv
// Purpose: directed bench for esta_stats
// Assumes: four ports, one second shortened to ten cycles
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/100ps
module esta_stats_bench;
    localparam int TICK = 10;
    logic clock, nrst, rd_req, rd_valid, req_done, fail_done, fail_gmrp, clr_one, clr_all;
    logic rx_done, rx_fcs_bad, rx_dribble, rx_mac_err, rx_pause, rx_stp, rx_rstp, rx_gvrp;
    logic rx_gmrp, tx_done, tx_ok, tx_fcs_bad, tx_underrun, tx_excess, tx_pause, tx_stp;
    logic tx_rstp, tx_gvrp, tx_gmrp;
    logic [3:0] half_duplex;
    logic [1:0] rx_port, tx_port, req_port, fail_port, clr_port, rd_port;
    logic [4:0] tx_coll;
    logic [5:0] rd_sel;
    logic [31:0] rd_data;
    esta_pkg::esta_len_t rx_len, tx_len;
    esta_pkg::esta_dst_e req_dst;
    int err_count = 0, check_count = 0, cycles = 0;
    esta_mac_model esta_mac_model_inst (.*);
    esta_stats #(.TICK_CYCLES(TICK)) esta_stats_inst (.*);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [1:0] p, input logic [5:0] s, input logic [31:0] exp);
        {rd_port, rd_sel, rd_req} = {p, s, 1'b1};
        @(posedge clock);
        #1;
        rd_req = 1'b0;
        chk("read valid", 32'h1, {31'h0, rd_valid});
        chk($sformatf("slot %0d port %0d", s, p), exp, rd_data);
        @(posedge clock);
        #1;
    endtask
    // table entry: port, select, expected count
    task automatic rd_e(input logic [15:0] e);
        rd(e[15:14], e[13:8], {24'h0, e[7:0]});
    endtask
    task automatic clr(input logic all, input logic [1:0] p);
        {clr_all, clr_one, clr_port} = {all, !all, p};
        @(posedge clock);
        #1;
        {clr_all, clr_one} = 2'h0;
    endtask
    task automatic ev(input logic [1:0] d, input logic gm);
        {req_done, req_port, fail_done, fail_port, fail_gmrp} = {1'b1, 2'h2, 1'b1, 2'h2, gm};
        req_dst = esta_pkg::esta_dst_e'(d);
        @(posedge clock);
        #1;
        {req_done, fail_done} = 2'h0;
        @(posedge clock);
        #1;
    endtask
    task automatic t_rx;
        logic [15:0] ln [4] = '{16'h0040, 16'h0064, 16'h05EF, 16'h0640};
        logic [7:0] fl [4] = '{8'h80, 8'hC0, 8'h80, 8'h20};
        logic [15:0] t [9] = '{16'h4001, 16'h4101, 16'h4201, 16'h4301, 16'h4502, 16'h4601,
                               16'h4B01, 16'h4C01, 16'h4D05};
        clr(1'b1, 2'h0);
        esta_mac_model_inst.rx(2'h1, 16'h003F, 8'h00);
        rd(2'h1, 6'h00, 32'h1);
        foreach (ln[i]) begin
            esta_mac_model_inst.rx(2'h1, ln[i], fl[i]);
            @(posedge clock);
            #1;
        end
        foreach (t[i]) rd_e(t[i]);
        $display("t_rx done");
    endtask
    task automatic t_tx;
        logic [15:0] ln [4] = '{16'h0400, 16'h0640, 16'h00C8, 16'h012C};
        logic [13:0] fl [4] = '{14'h20C0, 14'h0430, 14'h1000, 14'h080B};
        logic [15:0] t [18] = '{16'hCF01, 16'hD101, 16'hD201, 16'hD401, 16'hD501, 16'hD602,
                                16'hDA01, 16'hDB01, 16'hDC01, 16'hDD01, 16'hDE01, 16'hDF01,
                                16'hEB14, 16'hEC03, 16'hED03, 16'hE401, 16'hE101, 16'hE901};
        clr(1'b1, 2'h0);
        esta_mac_model_inst.tx(2'h3, 16'h0040, 14'h2040);
        rd(2'h3, 6'h0E, 32'h40);
        foreach (ln[i]) begin
            esta_mac_model_inst.tx(2'h3, ln[i], fl[i]);
            @(posedge clock);
            #1;
        end
        rd(2'h3, 6'h0E, 32'hC74);
        foreach (t[i]) rd_e(t[i]);
        $display("t_tx done");
    endtask
    task automatic t_ctrl;
        logic [15:0] t [9] = '{16'h0401, 16'hA400, 16'hA001, 16'hA501, 16'h9701, 16'h9801,
                               16'h9901, 16'hA702, 16'hAA02};
        half_duplex = 4'h4;
        clr(1'b1, 2'h0);
        rd(2'h2, 6'h04, 32'h0);
        clr(1'b1, 2'h0);
        esta_mac_model_inst.rx(2'h2, 16'h0040, 8'h1A);
        rd(2'h2, 6'h04, 32'h0);
        esta_mac_model_inst.rx(2'h0, 16'h0040, 8'h10);
        esta_mac_model_inst.tx(2'h2, 16'h0040, 14'h2018);
        for (int d = 0; d < 4; d++) ev(d[1:0], d[0]);
        foreach (t[i]) rd_e(t[i]);
        clr(1'b0, 2'h2);
        rd(2'h2, 6'h25, 32'h0);
        rd(2'h0, 6'h04, 32'h1);
        rd(2'h0, 6'h3F, 32'h0);
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        nrst = 1'b1;
        rd(2'h0, 6'h04, 32'h0);
        $display("t_ctrl done");
    endtask
    task automatic t_uptime;
        clr(1'b1, 2'h0);
        repeat (64 * TICK) @(posedge clock);
        #1;
        rd(2'h0, 6'h2E, 32'h4);
        rd(2'h0, 6'h2F, 32'h1);
        rd(2'h0, 6'h30, 32'h0);
        $display("t_uptime done");
    endtask
    initial begin
        {nrst, half_duplex, req_done, fail_done, clr_one, clr_all, rd_req} = '0;
        {req_port, fail_port, fail_gmrp, clr_port, rd_port, rd_sel} = '0;
        req_dst = esta_pkg::ESTA_DST_UC;
        repeat (6) @(posedge clock);
        #1;
        nrst = 1'b1;
        t_rx();
        t_tx();
        t_ctrl();
        t_uptime();
        close_out();
    end
endmodule // esta_stats_bench
